// ==== rtl/rai_pkg.sv ====
// Shared constants and types for the reader activation and switching I/O control block.
`default_nettype none

package rai_pkg;

	// ------------------------------------------------------------
	// Request services and object paths
	// ------------------------------------------------------------
	localparam logic [7:0] SVC_GET = 8'h0e;
	localparam logic [7:0] SVC_SET = 8'h10;
	localparam logic [7:0] CLS_SWIO = 8'h67;
	localparam logic [7:0] CLS_ACT = 8'h6a;
	localparam logic [7:0] INST_ONE = 8'h01;
	localparam logic [7:0] INST_TWO = 8'h02;

	// ------------------------------------------------------------
	// Attribute numbers
	// ------------------------------------------------------------
	localparam logic [7:0] ATTR_RSV_LAST = 8'h04;
	localparam logic [7:0] ATTR_SIG = 8'h05;
	localparam logic [7:0] ATTR_DRIVE = 8'h06;
	localparam logic [7:0] ATTR_CLEAR = 8'h07;
	localparam logic [7:0] ATTR_CMP = 8'h08;
	localparam logic [7:0] ATTR_CMP_TGL = 8'h09;
	localparam logic [7:0] ATTR_MODE = 8'h01;
	localparam logic [7:0] ATTR_COUNT = 8'h02;
	localparam logic [7:0] ATTR_GATE = 8'h03;
	localparam logic [7:0] ATTR_ACK = 8'h04;
	localparam logic [7:0] ATTR_DRST = 8'h05;

	// ------------------------------------------------------------
	// Configuration image layout and reset values
	// ------------------------------------------------------------
	localparam int CFG_BYTES = 3;
	localparam int CFG_MODE_BYTE = 0;
	localparam int CFG_RFRAG_BYTE = 1;
	localparam int CFG_IFRAG_BYTE = 2;
	localparam int CFG_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic ATTR_RESET = 1'b0;

	// ------------------------------------------------------------
	// Answer status codes
	// ------------------------------------------------------------
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_ERR_PATH = 8'h05;
	localparam logic [7:0] ST_ERR_SVC = 8'h08;
	localparam logic [7:0] ST_ERR_RO = 8'h0e;
	localparam logic [7:0] ST_ERR_ATTR = 8'h14;

	// ------------------------------------------------------------
	// Result store and event counter
	// ------------------------------------------------------------
	localparam int RES_W = 8;
	localparam int RES_DEPTH = 256;
	localparam int PTR_W = 8;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

	typedef enum logic [1:0]
	{
		RAI_IDLE = 2'b00,
		RAI_SHOWN = 2'b01
	} rai_pres_t;

endpackage : rai_pkg

`default_nettype wire

// ==== rtl/rai_channel.sv ====
// One switching channel: output drive, signal state, event counter and comparison flags.
`default_nettype none

module rai_channel
	import rai_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic pin_in,
	input wire logic drive_we,
	input wire logic clear_we,
	input wire logic wbit,
	input wire logic event_pulse,
	input wire logic [rai_pkg::CNT_W-1:0] compare_value,
	input wire logic repeat_mode,
	output logic pin_out,
	output logic clear_q,
	output logic signal_state,
	output logic compare_state,
	output logic compare_toggle
);
	logic [CNT_W-1:0] cnt_q;
	logic clear_rise;
	logic over;

	assign clear_rise = clear_we && wbit && !clear_q;
	assign over = cnt_q > compare_value;

	// ------------------------------------------------------------
	// Attribute storage and pins
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			pin_out <= ATTR_RESET;
			clear_q <= ATTR_RESET;
			signal_state <= ATTR_RESET;
		end
		else
		begin
			signal_state <= pin_in;
			if (drive_we)
				pin_out <= wbit;
			if (clear_we)
				clear_q <= wbit;
		end
	end

	// ------------------------------------------------------------
	// Event counter and comparison
	// ------------------------------------------------------------
	// In the repeated mode the counter restarts once passed, so that it can pass again.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn || clear_rise)
		begin
			cnt_q <= CNT_RESET;
			compare_state <= 1'b0;
			compare_toggle <= 1'b0;
		end
		else
		begin
			if (over)
				compare_state <= 1'b1;
			if (over && repeat_mode)
			begin
				compare_toggle <= !compare_toggle;
				cnt_q <= CNT_RESET;
			end
			else if (event_pulse && cnt_q != {CNT_W{1'b1}})
				cnt_q <= cnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_clear_rise: assert property (clear_rise |=> cnt_q == CNT_RESET && !compare_state
		&& !compare_toggle) else $error("counter clear did not return flags");
	a_drive_write: assert property (drive_we |=> pin_out == $past(wbit))
		else $error("output drive not applied");
	a_cmp_flag: assert property (over && !clear_rise |=> compare_state)
		else $error("comparison state not set after exceed");
	a_cmp_toggle: assert property (over && repeat_mode && !clear_rise
		|=> compare_toggle != $past(compare_toggle))
		else $error("comparison toggle did not invert");
	c_toggle_seen: cover property (over && repeat_mode ##1 compare_toggle);

endmodule : rai_channel

`default_nettype wire

// ==== rtl/rai_top.sv ====
// Attribute service, configuration image, activation and result handshake of the reader.
`default_nettype none

module rai_top
	import rai_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cfg_valid,
	input wire logic [7:0] cfg_byte0,
	input wire logic [7:0] cfg_byte1,
	input wire logic [7:0] cfg_byte2,
	input wire logic req_valid,
	input wire logic [7:0] req_service,
	input wire logic [7:0] req_class,
	input wire logic [7:0] req_instance,
	input wire logic [7:0] req_attr,
	input wire logic [7:0] req_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_status,
	output logic [7:0] rsp_rdata,
	input wire logic sw1_pin_in,
	output logic sw1_pin_out,
	input wire logic sw1_event,
	input wire logic [rai_pkg::CNT_W-1:0] sw1_compare_value,
	input wire logic sw1_repeat_mode,
	input wire logic sw2_pin_in,
	output logic sw2_pin_out,
	input wire logic sw2_event,
	input wire logic [rai_pkg::CNT_W-1:0] sw2_compare_value,
	input wire logic sw2_repeat_mode,
	input wire logic res_valid,
	input wire logic [rai_pkg::RES_W-1:0] res_data,
	output logic res_ready,
	output logic [rai_pkg::RES_W-1:0] area_data,
	output logic area_new_toggle,
	output logic gate_open,
	output logic handshake_en,
	output logic result_fragment_en,
	output logic input_fragment_en
);
	import rai_pkg::*;

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	logic is_get;
	logic is_set;
	logic hit_swio;
	logic hit_act;
	logic ch_two;
	logic wr;
	logic wbit;
	logic [1:0] drive_we;
	logic [1:0] clear_we;
	logic mode_we;
	logic gate_we;
	logic ack_we;
	logic drst_we;

	assign is_get = req_service == SVC_GET;
	assign is_set = req_service == SVC_SET;
	assign hit_swio = req_class == CLS_SWIO
		&& (req_instance == INST_ONE || req_instance == INST_TWO);
	assign hit_act = req_class == CLS_ACT && req_instance == INST_ONE;
	assign ch_two = req_instance == INST_TWO;
	assign wr = req_valid && is_set;
	assign wbit = req_wdata[0];
	assign drive_we[0] = wr && hit_swio && !ch_two && req_attr == ATTR_DRIVE;
	assign drive_we[1] = wr && hit_swio && ch_two && req_attr == ATTR_DRIVE;
	assign clear_we[0] = wr && hit_swio && !ch_two && req_attr == ATTR_CLEAR;
	assign clear_we[1] = wr && hit_swio && ch_two && req_attr == ATTR_CLEAR;
	assign mode_we = wr && hit_act && req_attr == ATTR_MODE;
	assign gate_we = wr && hit_act && req_attr == ATTR_GATE;
	assign ack_we = wr && hit_act && req_attr == ATTR_ACK;
	assign drst_we = wr && hit_act && req_attr == ATTR_DRST;

	// ------------------------------------------------------------
	// Switching channels
	// ------------------------------------------------------------
	logic [1:0] ch_clear_q;
	logic [1:0] ch_sig;
	logic [1:0] ch_cmp;
	logic [1:0] ch_tgl;

	rai_channel u_switching_channel_one (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin_in(sw1_pin_in),
		.drive_we(drive_we[0]),
		.clear_we(clear_we[0]),
		.wbit(wbit),
		.event_pulse(sw1_event),
		.compare_value(sw1_compare_value),
		.repeat_mode(sw1_repeat_mode),
		.pin_out(sw1_pin_out),
		.clear_q(ch_clear_q[0]),
		.signal_state(ch_sig[0]),
		.compare_state(ch_cmp[0]),
		.compare_toggle(ch_tgl[0])
	);

	rai_channel u_switching_channel_two (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin_in(sw2_pin_in),
		.drive_we(drive_we[1]),
		.clear_we(clear_we[1]),
		.wbit(wbit),
		.event_pulse(sw2_event),
		.compare_value(sw2_compare_value),
		.repeat_mode(sw2_repeat_mode),
		.pin_out(sw2_pin_out),
		.clear_q(ch_clear_q[1]),
		.signal_state(ch_sig[1]),
		.compare_state(ch_cmp[1]),
		.compare_toggle(ch_tgl[1])
	);

	// ------------------------------------------------------------
	// Configuration and activation attributes
	// ------------------------------------------------------------
	logic gate_trig_q;
	logic ack_q;
	logic drst_q;
	logic gate_rise;
	logic gate_fall;
	logic ack_evt;
	logic drst_evt;

	assign gate_rise = gate_we && wbit && !gate_trig_q;
	assign gate_fall = gate_we && !wbit && gate_trig_q;
	assign ack_evt = ack_we && (wbit != ack_q) && handshake_en;
	assign drst_evt = drst_we && wbit && !drst_q;

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			handshake_en <= CFG_RESET[CFG_BIT];
			result_fragment_en <= CFG_RESET[CFG_BIT];
			input_fragment_en <= CFG_RESET[CFG_BIT];
		end
		else if (cfg_valid)
		begin
			handshake_en <= cfg_byte0[CFG_BIT];
			result_fragment_en <= cfg_byte1[CFG_BIT];
			input_fragment_en <= cfg_byte2[CFG_BIT];
		end
		else if (mode_we)
			handshake_en <= wbit;
	end

	// Written values are kept so that the next write can be compared for an edge.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			gate_trig_q <= ATTR_RESET;
			ack_q <= ATTR_RESET;
			drst_q <= ATTR_RESET;
			gate_open <= 1'b0;
		end
		else
		begin
			if (gate_we)
				gate_trig_q <= wbit;
			if (ack_we)
				ack_q <= wbit;
			if (drst_we)
				drst_q <= wbit;
			if (gate_rise)
				gate_open <= 1'b1;
			else if (gate_fall)
				gate_open <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Result store and handshake
	// ------------------------------------------------------------
	logic [RES_W-1:0] mem [RES_DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [7:0] count_q;
	rai_pres_t pres_q;
	logic push;
	logic pop;
	logic show;
	logic last_ack;

	// The store is only used with handshake; plain output passes each result straight through.
	assign res_ready = !handshake_en || count_q != COUNT_MAX;
	assign push = res_valid && res_ready && handshake_en && !drst_evt;
	assign pop = pres_q == RAI_SHOWN && ack_evt && !drst_evt;
	assign show = pres_q == RAI_IDLE && count_q != 8'h00 && handshake_en && !drst_evt;
	assign last_ack = pop && count_q == 8'h01 && !push;

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr_q] <= res_data;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn || drst_evt)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= 8'h00;
			pres_q <= RAI_IDLE;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 8'h01;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 8'h01;
			if (push && !pop)
				count_q <= count_q + 8'h01;
			else if (pop && !push)
				count_q <= count_q - 8'h01;
			case (pres_q)
				RAI_IDLE:
					if (show)
						pres_q <= RAI_SHOWN;
				RAI_SHOWN:
					if (pop || !handshake_en)
						pres_q <= RAI_IDLE;
				default:
					pres_q <= RAI_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn || drst_evt)
		begin
			area_data <= '0;
			area_new_toggle <= 1'b0;
		end
		else if (!handshake_en && res_valid)
		begin
			area_data <= res_data;
			area_new_toggle <= !area_new_toggle;
		end
		else if (show)
		begin
			area_data <= mem[rd_ptr_q];
			area_new_toggle <= !area_new_toggle;
		end
		else if (last_ack)
			area_data <= '0;
	end

	// ------------------------------------------------------------
	// Answer
	// ------------------------------------------------------------
	logic [7:0] st_d;
	logic [7:0] rd_d;
	logic ro_attr;

	always_comb
	begin
		st_d = ST_OK;
		rd_d = 8'h00;
		ro_attr = 1'b0;
		if (!is_get && !is_set)
			st_d = ST_ERR_SVC;
		else if (hit_swio)
		begin
			case (req_attr)
				ATTR_SIG:
				begin
					rd_d = {7'h00, ch_sig[ch_two]};
					ro_attr = 1'b1;
				end
				ATTR_DRIVE:
					rd_d = {7'h00, ch_two ? sw2_pin_out : sw1_pin_out};
				ATTR_CLEAR:
					rd_d = {7'h00, ch_clear_q[ch_two]};
				ATTR_CMP:
				begin
					rd_d = {7'h00, ch_cmp[ch_two]};
					ro_attr = 1'b1;
				end
				ATTR_CMP_TGL:
				begin
					rd_d = {7'h00, ch_tgl[ch_two]};
					ro_attr = 1'b1;
				end
				default:
					st_d = ST_ERR_ATTR;
			endcase
		end
		else if (hit_act)
		begin
			case (req_attr)
				ATTR_MODE:
					rd_d = {7'h00, handshake_en};
				ATTR_COUNT:
				begin
					rd_d = count_q;
					ro_attr = 1'b1;
				end
				ATTR_GATE:
					rd_d = {7'h00, gate_trig_q};
				ATTR_ACK:
					rd_d = {7'h00, ack_q};
				ATTR_DRST:
					rd_d = {7'h00, drst_q};
				default:
					st_d = ST_ERR_ATTR;
			endcase
		end
		else
			st_d = ST_ERR_PATH;
		if (st_d == ST_OK && is_set && ro_attr)
			st_d = ST_ERR_RO;
	end

	// Attribute writes above act only where the answer is OK: a valid path and a writable attribute.
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rsp_valid <= 1'b0;
			rsp_status <= ST_OK;
			rsp_rdata <= 8'h00;
		end
		else
		begin
			rsp_valid <= req_valid;
			if (req_valid)
			begin
				rsp_status <= st_d;
				rsp_rdata <= is_get ? rd_d : 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_rsp_one_cycle: assert property (req_valid |=> rsp_valid)
		else $error("request not answered next cycle");
	a_bad_class: assert property (req_valid && (is_get || is_set) && !hit_swio && !hit_act
		|=> rsp_status == ST_ERR_PATH) else $error("unknown path accepted");
	a_reserved_attr: assert property (req_valid && (is_get || is_set) && hit_swio
		&& req_attr <= ATTR_RSV_LAST |=> rsp_status == ST_ERR_ATTR)
		else $error("reserved channel attribute accepted");
	a_cfg_load: assert property (cfg_valid |=> handshake_en == $past(cfg_byte0[CFG_BIT])
		&& result_fragment_en == $past(cfg_byte1[CFG_BIT]))
		else $error("configuration image not loaded");
	a_gate_rise: assert property (gate_rise |=> gate_open ##1 gate_open || $past(gate_we))
		else $error("reading gate did not open");
	a_hold_pending: assert property (pres_q == RAI_SHOWN && handshake_en && !ack_evt
		&& !drst_evt |=> $stable(area_data)) else $error("pending result changed");
	a_last_ack_zero: assert property (last_ack |=> area_data == '0 && count_q == 8'h00)
		else $error("input area not cleared after last ack");
	a_drst_clears: assert property (drst_evt |=> count_q == 8'h00 && area_data == '0
		&& !area_new_toggle) else $error("data reset incomplete");
	a_show_toggle: assert property (show |=> area_new_toggle != $past(area_new_toggle))
		else $error("new-result flag did not invert");

	c_handshake_pop: cover property (show ##[1:20] pop);
	c_full_store: cover property (count_q == COUNT_MAX);
	c_gate_cycle: cover property (gate_rise ##[1:50] gate_fall);

endmodule : rai_top

`default_nettype wire

// ==== testbench/rai_ctrl_model.sv ====
// Controller-side model that sends the configuration image and attribute requests.
`default_nettype none

module rai_ctrl_model
(
	input wire logic clk_sys,
	output logic cfg_valid,
	output logic [7:0] cfg_byte0,
	output logic [7:0] cfg_byte1,
	output logic [7:0] cfg_byte2,
	output logic req_valid,
	output logic [7:0] req_service,
	output logic [7:0] req_class,
	output logic [7:0] req_instance,
	output logic [7:0] req_attr,
	output logic [7:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_status,
	input wire logic [7:0] rsp_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import rai_pkg::*;

	logic ack_q;

	initial
	begin
		{cfg_valid, cfg_byte0, cfg_byte1, cfg_byte2} = '0;
		{req_valid, req_service, req_class, req_instance, req_attr, req_wdata} = '0;
		ack_q = 1'b0;
	end

	// ------------------------------------------------------------
	// Requests
	// ------------------------------------------------------------
	// A missing answer reads back as status 0xff so the caller sees a mismatch.
	task automatic xfer(input logic [7:0] svc, input logic [7:0] cls, input logic [7:0] inst,
		input logic [7:0] attr, input logic [7:0] wd, output logic [7:0] st, output logic [7:0] rd);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_service <= svc;
		req_class <= cls;
		req_instance <= inst;
		req_attr <= attr;
		req_wdata <= wd;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		req_attr <= ~attr;
		req_wdata <= ~wd;
		@(posedge clk_sys);
		st = (rsp_valid === 1'b1) ? rsp_status : 8'hff;
		rd = rsp_rdata;
	endtask : xfer

	// The image goes out once while the connection is set up.
	task automatic send_cfg(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		@(posedge clk_sys);
		cfg_valid <= 1'b1;
		{cfg_byte0, cfg_byte1, cfg_byte2} <= {b0, b1, b2};
		@(posedge clk_sys);
		cfg_valid <= 1'b0;
		{cfg_byte0, cfg_byte1, cfg_byte2} <= ~{b0, b1, b2};
		@(posedge clk_sys);
	endtask : send_cfg

	// Acknowledge by inverting the stored bit; only after the shown result was read.
	task automatic ack(output logic [7:0] st);
		logic [7:0] rd;
		ack_q = ~ack_q;
		xfer(SVC_SET, CLS_ACT, INST_ONE, ATTR_ACK, {7'h00, ack_q}, st, rd);
	endtask : ack

endmodule : rai_ctrl_model

`default_nettype wire

// ==== testbench/reader_activation_io_control_test.sv ====
// Self-checking bench for the reader activation and switching I/O control block.
`default_nettype none

module reader_activation_io_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rai_pkg::*;

	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cfg_valid, req_valid, rsp_valid, res_valid = 1'b0, res_ready;
	logic [7:0] cfg_byte0, cfg_byte1, cfg_byte2, req_service, req_class, req_instance;
	logic [7:0] req_attr, req_wdata, rsp_status, rsp_rdata, res_data = 8'h00, area_data;
	logic [1:0] sw_pin_in = 2'b00, sw_pin_out, sw_event = 2'b00, sw_rep = 2'b00;
	logic [CNT_W-1:0] cmpv [2] = '{16'h0002, 16'h0002};
	logic area_new_toggle, gate_open, handshake_en, result_fragment_en, input_fragment_en;
	logic [7:0] st, rd, inst;
	logic t_exp = 1'b0;
	int n_fail = 0, n_tests = 0, cyc = 0;

	always #5 clk_sys = ~clk_sys;

	rai_ctrl_model u_ctrl (.clk_sys(clk_sys), .cfg_valid(cfg_valid), .cfg_byte0(cfg_byte0),
		.cfg_byte1(cfg_byte1), .cfg_byte2(cfg_byte2), .req_valid(req_valid),
		.req_service(req_service), .req_class(req_class), .req_instance(req_instance),
		.req_attr(req_attr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_status(rsp_status), .rsp_rdata(rsp_rdata));

	rai_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .cfg_valid(cfg_valid), .cfg_byte0(cfg_byte0),
		.cfg_byte1(cfg_byte1), .cfg_byte2(cfg_byte2), .req_valid(req_valid),
		.req_service(req_service), .req_class(req_class), .req_instance(req_instance),
		.req_attr(req_attr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_status(rsp_status), .rsp_rdata(rsp_rdata), .sw1_pin_in(sw_pin_in[0]),
		.sw1_pin_out(sw_pin_out[0]), .sw1_event(sw_event[0]), .sw1_compare_value(cmpv[0]),
		.sw1_repeat_mode(sw_rep[0]), .sw2_pin_in(sw_pin_in[1]), .sw2_pin_out(sw_pin_out[1]),
		.sw2_event(sw_event[1]), .sw2_compare_value(cmpv[1]), .sw2_repeat_mode(sw_rep[1]),
		.res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
		.area_data(area_data), .area_new_toggle(area_new_toggle), .gate_open(gate_open),
		.handshake_en(handshake_en), .result_fragment_en(result_fragment_en),
		.input_fragment_en(input_fragment_en));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic get_chk(input logic [7:0] cls, input logic [7:0] ins, input logic [7:0] attr,
		input logic [7:0] exp);
		u_ctrl.xfer(SVC_GET, cls, ins, attr, 8'h00, st, rd);
		check(st, ST_OK);
		check(rd, exp);
	endtask : get_chk

	task automatic set_chk(input logic [7:0] cls, input logic [7:0] ins, input logic [7:0] attr,
		input logic [7:0] wd);
		u_ctrl.xfer(SVC_SET, cls, ins, attr, wd, st, rd);
		check(st, ST_OK);
	endtask : set_chk

	task automatic err_chk(input logic [7:0] svc, input logic [7:0] cls, input logic [7:0] ins,
		input logic [7:0] attr, input logic [7:0] exp_st);
		u_ctrl.xfer(svc, cls, ins, attr, 8'h01, st, rd);
		check(st, exp_st);
	endtask : err_chk

	// Results are offered back to back, one word per cycle, counting up from base.
	task automatic push_seq(input int n, input logic [7:0] base);
		@(posedge clk_sys);
		res_valid <= 1'b1;
		res_data <= base;
		repeat (n - 1) @(posedge clk_sys) res_data <= res_data + 8'h01;
		@(posedge clk_sys);
		res_valid <= 1'b0;
		res_data <= ~res_data;
		repeat (4) @(posedge clk_sys);
	endtask : push_seq

	task automatic pulse(input int i, input int n);
		repeat (n)
		begin
			@(posedge clk_sys) sw_event[i] <= 1'b1;
			@(posedge clk_sys) sw_event[i] <= 1'b0;
		end
		repeat (3) @(posedge clk_sys);
	endtask : pulse

	task automatic ack_wait();
		u_ctrl.ack(st);
		check(st, ST_OK);
		repeat (3) @(posedge clk_sys);
	endtask : ack_wait

	task automatic conclude();
		$display("counts: %0d comparisons, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// The whole run needs well under a thousand cycles; this cuts a hang short.
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		check({5'h00, handshake_en, result_fragment_en, input_fragment_en}, 8'h00);
		for (int a = 1; a <= 5; a++) get_chk(CLS_ACT, INST_ONE, 8'(a), 8'h00);
		for (int a = 5; a <= 9; a++) get_chk(CLS_SWIO, INST_TWO, 8'(a), 8'h00);
		$display("test reset values done");

		for (int a = 1; a <= 4; a++)
			err_chk(SVC_GET, CLS_SWIO, INST_ONE, 8'(a), ST_ERR_ATTR);
		err_chk(8'h01, CLS_ACT, INST_ONE, ATTR_COUNT, ST_ERR_SVC);
		err_chk(SVC_GET, 8'h6b, INST_ONE, ATTR_COUNT, ST_ERR_PATH);
		err_chk(SVC_GET, CLS_SWIO, 8'h03, ATTR_SIG, ST_ERR_PATH);
		err_chk(SVC_SET, CLS_SWIO, INST_ONE, ATTR_CMP, ST_ERR_RO);
		err_chk(SVC_SET, CLS_ACT, INST_ONE, ATTR_COUNT, ST_ERR_RO);
		$display("test refusals done");

		u_ctrl.send_cfg(8'hfe, 8'h01, 8'hff);
		check({5'h00, handshake_en, result_fragment_en, input_fragment_en}, 8'h03);
		get_chk(CLS_ACT, INST_ONE, ATTR_MODE, 8'h00);
		$display("test configuration done");

		for (int i = 0; i < 2; i++)
		begin
			inst = 8'(i + 1);
			set_chk(CLS_SWIO, inst, ATTR_DRIVE, 8'h01);
			check({7'h00, sw_pin_out[i]}, 8'h01);
			set_chk(CLS_SWIO, inst, ATTR_DRIVE, 8'h00);
			check({7'h00, sw_pin_out[i]}, 8'h00);
			sw_pin_in[i] <= 1'b1;
			get_chk(CLS_SWIO, inst, ATTR_SIG, 8'h01);
			sw_pin_in[i] <= 1'b0;
			get_chk(CLS_SWIO, inst, ATTR_SIG, 8'h00);
			pulse(i, 3);
			get_chk(CLS_SWIO, inst, ATTR_CMP, 8'h01);
			set_chk(CLS_SWIO, inst, ATTR_CLEAR, 8'h01);
			get_chk(CLS_SWIO, inst, ATTR_CMP, 8'h00);
			pulse(i, 2);
			get_chk(CLS_SWIO, inst, ATTR_CMP, 8'h00);
			set_chk(CLS_SWIO, inst, ATTR_CLEAR, 8'h00);
			pulse(i, 1);
			get_chk(CLS_SWIO, inst, ATTR_CMP, 8'h01);
			sw_rep[i] <= 1'b1;
			cmpv[i] <= 16'h0001;
			set_chk(CLS_SWIO, inst, ATTR_CLEAR, 8'h01);
			get_chk(CLS_SWIO, inst, ATTR_CMP_TGL, 8'h00);
			pulse(i, 2);
			get_chk(CLS_SWIO, inst, ATTR_CMP_TGL, 8'h01);
			pulse(i, 2);
			get_chk(CLS_SWIO, inst, ATTR_CMP_TGL, 8'h00);
			set_chk(CLS_SWIO, inst, ATTR_CLEAR, 8'h00);
			sw_rep[i] <= 1'b0;
		end
		$display("test switching channels done");

		set_chk(CLS_ACT, INST_ONE, ATTR_GATE, 8'h01);
		check({7'h00, gate_open}, 8'h01);
		set_chk(CLS_ACT, INST_ONE, ATTR_GATE, 8'h01);
		check({7'h00, gate_open}, 8'h01);
		set_chk(CLS_ACT, INST_ONE, ATTR_GATE, 8'h00);
		check({7'h00, gate_open}, 8'h00);
		$display("test reading gate done");

		push_seq(1, 8'h5a);
		t_exp = ~t_exp;
		check(area_data, 8'h5a);
		check({7'h00, area_new_toggle}, {7'h00, t_exp});
		get_chk(CLS_ACT, INST_ONE, ATTR_COUNT, 8'h00);
		ack_wait();
		check(area_data, 8'h5a);
		$display("test plain output done");

		set_chk(CLS_ACT, INST_ONE, ATTR_MODE, 8'h01);
		check({7'h00, handshake_en}, 8'h01);
		push_seq(3, 8'ha1);
		t_exp = ~t_exp;
		check(area_data, 8'ha1);
		check({7'h00, res_ready}, 8'h01);
		get_chk(CLS_ACT, INST_ONE, ATTR_COUNT, 8'h03);
		set_chk(CLS_ACT, INST_ONE, ATTR_ACK, {7'h00, u_ctrl.ack_q});
		check(area_data, 8'ha1);
		ack_wait();
		t_exp = ~t_exp;
		check(area_data, 8'ha2);
		get_chk(CLS_ACT, INST_ONE, ATTR_COUNT, 8'h02);
		ack_wait();
		t_exp = ~t_exp;
		check(area_data, 8'ha3);
		check({7'h00, area_new_toggle}, {7'h00, t_exp});
		ack_wait();
		check(area_data, 8'h00);
		get_chk(CLS_ACT, INST_ONE, ATTR_COUNT, 8'h00);
		$display("test handshake done");

		push_seq(2, 8'hb0);
		check(area_data, 8'hb0);
		// Two stored plus 254 offered: the store fills at 255 and refuses the last word.
		push_seq(254, 8'h10);
		check({7'h00, res_ready}, 8'h00);
		get_chk(CLS_ACT, INST_ONE, ATTR_COUNT, 8'hff);
		check(area_data, 8'hb0);
		set_chk(CLS_ACT, INST_ONE, ATTR_DRST, 8'h01);
		@(posedge clk_sys);
		check(area_data, 8'h00);
		check({7'h00, area_new_toggle}, 8'h00);
		check({7'h00, res_ready}, 8'h01);
		get_chk(CLS_ACT, INST_ONE, ATTR_COUNT, 8'h00);
		set_chk(CLS_ACT, INST_ONE, ATTR_DRST, 8'h00);
		$display("test data reset done");
		conclude();
	end

endmodule : reader_activation_io_control_test

`default_nettype wire
